// ### hdl/smt_transfer_core.sv
`timescale 1ns/1ps
module smt_transfer_core
    import smt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Program memory
    output logic      [10:0] pmAddr,
    input  wire logic [7:0]  pmData,
    // Buffer flags from the host interface
    input  wire logic        outFull,
    input  wire logic        inFull,
    // Host bus strobes, pins
    input  wire logic        hostRdN,
    input  wire logic        hostWrN,
    input  wire logic        hostCsN,
    output logic             hostSelN,
    output logic      [7:0]  hostStatus,
    // Port two bits four to seven
    input  wire logic [3:0]  portTwoIn,
    output logic      [3:0]  portTwoOut,
    output logic      [3:0]  portTwoOe
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        smt_seq_t                   seq;
        logic [7:0]                 opcode;
        logic [7:0]                 operand;
        logic                       badOp;
        logic [7:0]                 acc;
        logic [7:0]                 statusWord;
        logic [3:0]                 stHigh;
        logic [7:0][7:0]            wreg;
        logic [RAM_DEPTH-1:0][7:0]  ram;
        logic [7:0]                 ptLatch;
        logic [2:0]                 page;
        logic                       dmaMode;
        logic                       flagMode;
        logic                       dmaReq;
        logic [10:0]                pmAddr;
        logic [6:0]                 sync1;
        logic [6:0]                 sync2;
        logic [6:0]                 sync3;
        logic [6:0]                 pins;
        logic                       wrPend;
        logic                       wrHit;
        logic [7:0]                 wrAddr;
        logic [31:0]                hrdata;
    } smt_core_t;

    smt_core_t stateReg;
    smt_core_t stateNext;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic opHit(input logic [7:0] op, input logic [7:0] base, input logic [7:0] mask);
        return (op & mask) == base;
    endfunction

    function automatic logic [31:0] readWord(input smt_core_t s, input logic hit, input logic [7:0] a,
                                             input logic ofull, input logic ifull);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (hit) begin
            if (a == OFS_CMD) begin
                w[15:0]          = {s.operand, s.opcode};
                w[CMD_BUSY_BIT]  = (s.seq != SEQ_IDLE);
                w[CMD_BADOP_BIT] = s.badOp;
            end else if (a == OFS_ACC) begin
                w[7:0] = s.acc;
            end else if (a == OFS_STW) begin
                w[7:0] = s.statusWord;
            end else if (a == OFS_HOST_STAT) begin
                w[7:0] = {s.stHigh, 1'b0, s.statusWord[STW_USER_FLAG], ifull, ofull};
            end else if (a == OFS_PORT_TWO) begin
                w[11:0] = {s.pins[3:0], s.ptLatch};
            end else if (a == OFS_MODE) begin
                w[MODE_DMA_BIT]  = s.dmaMode;
                w[MODE_FLAG_BIT] = s.flagMode;
                w[MODE_REQ_BIT]  = s.dmaReq;
            end else if (a == OFS_PAGE) begin
                w[2:0] = s.page;
            end else if (a >= OFS_WREG_BASE && a <= OFS_WREG_LAST) begin
                w[7:0] = s.wreg[a[4:2]];
            end
        end
        return w;
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [7:0]        op;
        logic [2:0]        rIdx;
        logic [RAM_AW-1:0] ptr;
        logic [7:0]        tmp;
        logic              ackCycle;
        logic              reqSet;
        logic              accessOk;
        logic              isTwoCycle;

        stateNext  = stateReg;
        op         = stateReg.opcode;
        rIdx       = op[2:0];
        ptr        = stateReg.wreg[{2'b00, op[0]}][RAM_AW-1:0];
        tmp        = 8'h00;
        reqSet     = 1'b0;
        ackCycle   = 1'b0;
        accessOk   = 1'b0;
        isTwoCycle = opHit(op, OP_MOV_A_IMM, MASK_FULL) | opHit(op, OP_MOV_R_IMM, MASK_REG) |
                     opHit(op, OP_MOV_IND_IM, MASK_IND) | opHit(op, OP_PM_READ, MASK_FULL) |
                     opHit(op, OP_PM3_READ, MASK_FULL);

        // Pins: three stages, a level counts once stages two and three agree
        stateNext.sync1 = {hostCsN, hostWrN, hostRdN, portTwoIn};
        stateNext.sync2 = stateReg.sync1;
        stateNext.sync3 = stateReg.sync2;
        stateNext.pins  = (~(stateReg.sync2 ^ stateReg.sync3) & stateReg.sync3) |
                          ((stateReg.sync2 ^ stateReg.sync3) & stateReg.pins);

        // -----------------------------------------------------------
        // Instruction sequencer
        // -----------------------------------------------------------
        case (stateReg.seq)
            SEQ_IDLE: begin
            end
            SEQ_FIRST: begin
                stateNext.seq = SEQ_IDLE;
                if (isTwoCycle) begin
                    stateNext.seq = SEQ_SECOND;
                    if (opHit(op, OP_PM_READ, MASK_FULL))
                        stateNext.pmAddr = {stateReg.page, stateReg.acc};
                    else if (opHit(op, OP_PM3_READ, MASK_FULL))
                        stateNext.pmAddr = {PAGE_THREE, stateReg.acc};
                end else if (opHit(op, OP_MOV_A_R, MASK_REG)) begin
                    stateNext.acc = stateReg.wreg[rIdx];
                end else if (opHit(op, OP_MOV_R_A, MASK_REG)) begin
                    stateNext.wreg[rIdx] = stateReg.acc;
                end else if (opHit(op, OP_EXCH_R, MASK_REG)) begin
                    stateNext.acc        = stateReg.wreg[rIdx];
                    stateNext.wreg[rIdx] = stateReg.acc;
                end else if (opHit(op, OP_EXCH_IND, MASK_IND)) begin
                    stateNext.acc      = stateReg.ram[ptr];
                    stateNext.ram[ptr] = stateReg.acc;
                end else if (opHit(op, OP_MOV_A_IND, MASK_IND)) begin
                    stateNext.acc = stateReg.ram[ptr];
                end else if (opHit(op, OP_MOV_IND_A, MASK_IND)) begin
                    stateNext.ram[ptr] = stateReg.acc;
                end else if (opHit(op, OP_DIGIT_EXCH, MASK_IND)) begin
                    tmp                = stateReg.ram[ptr];
                    stateNext.acc      = {stateReg.acc[7:4], tmp[3:0]};
                    stateNext.ram[ptr] = {tmp[7:4], stateReg.acc[3:0]};
                end else if (opHit(op, OP_MOV_A_STW, MASK_FULL)) begin
                    stateNext.acc = stateReg.statusWord;
                end else if (opHit(op, OP_MOV_STW_A, MASK_FULL)) begin
                    // Carry and aux carry land at bits seven and six with the rest
                    stateNext.statusWord = stateReg.acc;
                end else if (opHit(op, OP_MOV_HST_A, MASK_FULL)) begin
                    stateNext.stHigh = stateReg.acc[7:4];
                end else if (opHit(op, OP_CLR_C, MASK_FULL)) begin
                    stateNext.statusWord[STW_CARRY] = 1'b0;
                end else if (opHit(op, OP_CPL_C, MASK_FULL)) begin
                    stateNext.statusWord[STW_CARRY] = ~stateReg.statusWord[STW_CARRY];
                end else if (opHit(op, OP_CLR_UFLAG, MASK_FULL)) begin
                    stateNext.statusWord[STW_USER_FLAG] = 1'b0;
                end else if (opHit(op, OP_CPL_UFLAG, MASK_FULL)) begin
                    stateNext.statusWord[STW_USER_FLAG] = ~stateReg.statusWord[STW_USER_FLAG];
                end else if (opHit(op, OP_EN_DMA, MASK_FULL)) begin
                    stateNext.dmaMode = 1'b1;
                end else if (opHit(op, OP_EN_FLAGS, MASK_FULL)) begin
                    stateNext.flagMode = 1'b1;
                end else begin
                    // Other groups belong to other units of the core
                    stateNext.badOp = 1'b1;
                end
            end
            SEQ_SECOND: begin
                stateNext.seq = SEQ_IDLE;
                if (opHit(op, OP_MOV_A_IMM, MASK_FULL))
                    stateNext.acc = stateReg.operand;
                else if (opHit(op, OP_MOV_R_IMM, MASK_REG))
                    stateNext.wreg[rIdx] = stateReg.operand;
                else if (opHit(op, OP_MOV_IND_IM, MASK_IND))
                    stateNext.ram[ptr] = stateReg.operand;
                else
                    stateNext.acc = pmData;
            end
            default: begin
                stateNext.seq = SEQ_IDLE;
            end
        endcase

        // -----------------------------------------------------------
        // Bus write data phase; ignored while an instruction runs
        // -----------------------------------------------------------
        accessOk = stateReg.wrPend & stateReg.wrHit & (stateReg.seq == SEQ_IDLE);
        if (accessOk) begin
            if (stateReg.wrAddr == OFS_CMD) begin
                stateNext.opcode  = hwdata[7:0];
                stateNext.operand = hwdata[15:8];
                stateNext.badOp   = 1'b0;
                stateNext.seq     = SEQ_FIRST;
            end else if (stateReg.wrAddr == OFS_ACC) begin
                stateNext.acc = hwdata[7:0];
            end else if (stateReg.wrAddr == OFS_STW) begin
                stateNext.statusWord = hwdata[7:0];
            end else if (stateReg.wrAddr == OFS_PORT_TWO) begin
                stateNext.ptLatch = hwdata[7:0];
                reqSet = stateReg.dmaMode & hwdata[PT_REQ_BIT];
            end else if (stateReg.wrAddr == OFS_PAGE) begin
                stateNext.page = hwdata[2:0];
            end else if (stateReg.wrAddr >= OFS_WREG_BASE && stateReg.wrAddr <= OFS_WREG_LAST) begin
                stateNext.wreg[stateReg.wrAddr[4:2]] = hwdata[7:0];
            end
        end

        // -----------------------------------------------------------
        // DMA request: a new request wins over a same-cycle drop
        // -----------------------------------------------------------
        ackCycle = stateReg.dmaMode & ~stateReg.pins[PT_ACK_BIT - 4] &
                   (~stateReg.pins[4] | ~stateReg.pins[5]);
        if (ackCycle | (stateReg.seq == SEQ_FIRST && opHit(op, OP_EN_DMA, MASK_FULL)))
            stateNext.dmaReq = 1'b0;
        if (reqSet)
            stateNext.dmaReq = 1'b1;

        // -----------------------------------------------------------
        // Bus address phase; read data sampled after this edge's updates
        // -----------------------------------------------------------
        stateNext.wrPend = 1'b0;
        if (hsel & hready & htrans[1]) begin
            stateNext.wrPend = hwrite;
            stateNext.wrHit  = (haddr[31:8] == 24'h00_0000) & (haddr[1:0] == 2'b00);
            stateNext.wrAddr = haddr[7:0];
            if (!hwrite)
                stateNext.hrdata = readWord(stateNext,
                                            (haddr[31:8] == 24'h00_0000) & (haddr[1:0] == 2'b00),
                                            haddr[7:0], outFull, inFull);
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stateReg          <= '0;
            stateReg.seq      <= SEQ_IDLE;
            stateReg.ptLatch  <= PT_RESET;
            stateReg.sync1    <= SYNC_RESET;
            stateReg.sync2    <= SYNC_RESET;
            stateReg.sync3    <= SYNC_RESET;
            stateReg.pins     <= SYNC_RESET;
        end else begin
            stateReg <= stateNext;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign hrdata    = stateReg.hrdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign pmAddr    = stateReg.pmAddr;

    // Acknowledge replaces chip select for buffer access in DMA mode
    assign hostSelN = stateReg.dmaMode ? stateReg.pins[PT_ACK_BIT - 4] : stateReg.pins[6];

    assign hostStatus = {stateReg.stHigh, 1'b0, stateReg.statusWord[STW_USER_FLAG], inFull, outFull};

    // Plain mode is quasi-bidirectional: a latched zero pulls low,
    // a latched one leaves the pin free to be read as an input.
    always_comb begin
        portTwoOut = stateReg.ptLatch[7:4];
        portTwoOe  = ~stateReg.ptLatch[7:4];
        if (stateReg.flagMode) begin
            portTwoOut[0] = outFull & stateReg.ptLatch[PT_OFULL_BIT];
            portTwoOut[1] = inFull & stateReg.ptLatch[PT_IFULL_BIT];
            portTwoOe[1:0] = 2'b11;
        end
        if (stateReg.dmaMode) begin
            portTwoOut[2] = stateReg.dmaReq;
            portTwoOe[2]  = 1'b1;
            portTwoOut[3] = 1'b0;
            portTwoOe[3]  = 1'b0;
        end
    end

endmodule

// ### hdl/smt_pkg.sv
package smt_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CMD       = 8'h00;
    localparam logic [7:0] OFS_ACC       = 8'h04;
    localparam logic [7:0] OFS_STW       = 8'h08;
    localparam logic [7:0] OFS_HOST_STAT = 8'h0C;
    localparam logic [7:0] OFS_PORT_TWO  = 8'h10;
    localparam logic [7:0] OFS_MODE      = 8'h14;
    localparam logic [7:0] OFS_PAGE      = 8'h18;
    localparam logic [7:0] OFS_WREG_BASE = 8'h20;
    localparam logic [7:0] OFS_WREG_LAST = 8'h3C;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CMD_BUSY_BIT  = 16;
    localparam int CMD_BADOP_BIT = 17;
    localparam int STW_CARRY     = 7;
    localparam int STW_AUX_CARRY = 6;
    localparam int STW_USER_FLAG = 5;
    localparam int MODE_DMA_BIT  = 0;
    localparam int MODE_FLAG_BIT = 1;
    localparam int MODE_REQ_BIT  = 2;
    localparam int PT_OFULL_BIT  = 4;
    localparam int PT_IFULL_BIT  = 5;
    localparam int PT_REQ_BIT    = 6;
    localparam int PT_ACK_BIT    = 7;

    // ---------------------------------------------------------------
    // Sizes and reset values
    // ---------------------------------------------------------------
    localparam int         RAM_DEPTH     = 64;
    localparam int         RAM_AW        = 6;
    localparam logic [7:0] PT_RESET      = 8'hFF;
    localparam logic [6:0] SYNC_RESET    = 7'h7F;
    localparam logic [2:0] PAGE_THREE    = 3'h3;

    // ---------------------------------------------------------------
    // Opcodes and group masks
    // ---------------------------------------------------------------
    localparam logic [7:0] MASK_FULL     = 8'hFF;
    localparam logic [7:0] MASK_REG      = 8'hF8;
    localparam logic [7:0] MASK_IND      = 8'hFE;
    localparam logic [7:0] OP_MOV_A_IMM  = 8'h23;
    localparam logic [7:0] OP_MOV_A_R    = 8'hF8;
    localparam logic [7:0] OP_MOV_R_A    = 8'hA8;
    localparam logic [7:0] OP_MOV_R_IMM  = 8'hB8;
    localparam logic [7:0] OP_EXCH_R     = 8'h28;
    localparam logic [7:0] OP_EXCH_IND   = 8'h20;
    localparam logic [7:0] OP_MOV_A_IND  = 8'hF0;
    localparam logic [7:0] OP_MOV_IND_A  = 8'hA0;
    localparam logic [7:0] OP_MOV_IND_IM = 8'hB0;
    localparam logic [7:0] OP_PM_READ    = 8'hA3;
    localparam logic [7:0] OP_PM3_READ   = 8'hE3;
    localparam logic [7:0] OP_DIGIT_EXCH = 8'h30;
    localparam logic [7:0] OP_MOV_A_STW  = 8'hC7;
    localparam logic [7:0] OP_MOV_STW_A  = 8'hD7;
    localparam logic [7:0] OP_MOV_HST_A  = 8'h90;
    localparam logic [7:0] OP_CLR_C      = 8'h97;
    localparam logic [7:0] OP_CPL_C      = 8'hA7;
    localparam logic [7:0] OP_CLR_UFLAG  = 8'h85;
    localparam logic [7:0] OP_CPL_UFLAG  = 8'h95;
    localparam logic [7:0] OP_EN_DMA     = 8'hE5;
    localparam logic [7:0] OP_EN_FLAGS   = 8'hF5;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_FIRST,
        SEQ_SECOND
    } smt_seq_t;

endpackage

// ### testbench/smt_transfer_core_assertions.sv
`timescale 1ns/1ps
module smt_checker (
    // Clock, reset and bus
    input wire logic        clk, nrst, hsel, hwrite, hreadyout, hresp,
    input wire logic [31:0] haddr, hrdata,
    input wire logic [1:0]  htrans,
    // Flags and pins
    input wire logic        outFull, inFull, hostCsN, hostSelN,
    input wire logic [7:0]  hostStatus,
    input wire logic [3:0]  portTwoIn, portTwoOut, portTwoOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_answer_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_reset_plain: assert property ($rose(nrst) |-> portTwoOe == 4'h0 && hostSelN)
        else $error("pins not plain after reset");
    a_ofull_gated: assert property (portTwoOe[0] && portTwoOut[0] |-> outFull)
        else $error("output flag pin high without its flag");
    a_ifull_gated: assert property (portTwoOe[1] && portTwoOut[1] |-> inFull)
        else $error("input flag pin high without its flag");
    a_status_flags: assert property (hostStatus[3] == 1'b0 && hostStatus[1:0] == {inFull, outFull})
        else $error("status flag bits differ from buffer flags");
    a_select_idle: assert property ((hostCsN && portTwoIn[3])[*5] |-> hostSelN)
        else $error("buffer selected with no select or acknowledge");
    a_unmapped_zero: assert property (hsel && htrans[1] && !hwrite && haddr == 32'h0000_001C |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_read_upper: assert property (hsel && htrans[1] && !hwrite |=> hrdata[31:18] == 14'h0)
        else $error("read data upper bits not zero");
endmodule

// ### testbench/smt_host_model.sv
`timescale 1ns/1ps
module smt_host_model (
    // Bench control
    input wire logic        clk, go, wr,
    input wire logic [3:0]  hold,
    // Host pins and program memory
    output logic            hostRdN, hostWrN, hostCsN, ackN,
    input wire logic [10:0] pmAddr,
    output logic      [7:0] pmData
);
    int cnt = 0;
    // Page folded into the byte so a wrong page shows
    assign pmData = pmAddr[7:0] ^ {pmAddr[10:8], 5'h00};
    assign hostCsN = 1'b1;
    assign ackN = (cnt == 0);
    assign hostRdN = wr || !(cnt > 1 && cnt < int'(hold) + 2);
    assign hostWrN = !wr || !(cnt > 1 && cnt < int'(hold) + 2);
    always @(posedge clk) cnt <= (cnt == 0) ? int'(go) : ((cnt > int'(hold) + 3) ? 0 : cnt + 1);
endmodule

// ### testbench/smt_transfer_core_tb_top.sv
`timescale 1ns/1ps
module smt_transfer_core_tb_top
    import smt_pkg::*;
;
    logic        clk = 0, nrst = 0, hsel = 0, hwrite = 0, go = 0, wr = 0, outFull = 1, inFull = 0;
    logic        hreadyout, hresp, hostRdN, hostWrN, hostCsN, hostSelN, ackN;
    logic [1:0]  htrans = 0;
    logic [3:0]  hold = 0, portTwoOe, portTwoOut;
    logic [7:0]  pmData, hostStatus;
    logic [10:0] pmAddr;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    int          n_errors = 0, n_tests = 0;
    smt_transfer_core u_smt_transfer_core (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pmAddr(pmAddr), .pmData(pmData), .outFull(outFull), .inFull(inFull), .hostRdN(hostRdN),
        .hostWrN(hostWrN), .hostCsN(hostCsN), .hostSelN(hostSelN), .hostStatus(hostStatus),
        .portTwoIn({ackN, 3'h7}), .portTwoOut(portTwoOut), .portTwoOe(portTwoOe));
    smt_host_model u_smt_host_model (.clk(clk), .go(go), .wr(wr), .hold(hold), .hostRdN(hostRdN),
        .hostWrN(hostWrN), .hostCsN(hostCsN), .ackN(ackN), .pmAddr(pmAddr), .pmData(pmData));
    initial begin forever #5 clk = ~clk; end
    // ---------------------------------------------------------------
    // Bus and check helpers
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic ex(input logic [7:0] op, input logic [7:0] n);
        bus(1'b1, OFS_CMD, {16'h0, n, op});
        do bus(1'b0, OFS_CMD, 32'h0); while (r[CMD_BUSY_BIT] !== 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, r);
    endtask
    task automatic ack(input logic w, input logic [3:0] h);
        @(posedge clk);
        wr <= w; hold <= h; go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk("ackSelect", 32'h0, {31'h0, hostSelN});
        repeat (int'(h) + 8) @(posedge clk);
    endtask
    task automatic complete_run;
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_moves;
        ex(OP_MOV_A_IMM, 8'h5A);
        ex(OP_MOV_R_IMM | 8'h05, 8'hC3);
        ex(OP_EXCH_R | 8'h05, 8'h00);
        rd(OFS_ACC, "xchReg", 32'h0000_00C3);
        ex(OP_MOV_R_A | 8'h03, 8'h00);
        ex(OP_MOV_A_R | 8'h05, 8'h00);
        rd(OFS_ACC, "movAR", 32'h0000_005A);
        rd(OFS_WREG_BASE + 8'h0C, "movRA", 32'h0000_00C3);
        rd(8'h1C, "unmapped", 32'h0);
        ex(8'h00, 8'h00);
        rd(OFS_CMD, "badOp", 32'h0002_0000);
    endtask
    task automatic t_memory;
        ex(OP_MOV_R_IMM | 8'h01, 8'h07);
        ex(OP_MOV_IND_IM | 8'h01, 8'h9E);
        ex(OP_MOV_A_IMM, 8'h21);
        ex(OP_DIGIT_EXCH | 8'h01, 8'h00);
        rd(OFS_ACC, "digitXch", 32'h0000_002E);
        ex(OP_EXCH_IND | 8'h01, 8'h00);
        ex(OP_MOV_A_IND | 8'h01, 8'h00);
        rd(OFS_ACC, "indirect", 32'h0000_002E);
        bus(1'b1, OFS_PAGE, 32'h0000_0002);
        ex(OP_PM_READ, 8'h00);
        rd(OFS_ACC, "pageRead", 32'h0000_006E);
        ex(OP_PM3_READ, 8'h00);
        rd(OFS_ACC, "pageThree", 32'h0000_000E);
    endtask
    task automatic t_status;
        ex(OP_MOV_A_IMM, 8'hD5);
        ex(OP_MOV_STW_A, 8'h00);
        ex(OP_CLR_C, 8'h00);
        ex(OP_CPL_UFLAG, 8'h00);
        rd(OFS_STW, "statusWord", 32'h0000_0075);
        ex(OP_CLR_UFLAG, 8'h00);
        ex(OP_CPL_C, 8'h00);
        ex(OP_MOV_A_STW, 8'h00);
        rd(OFS_ACC, "accStatus", 32'h0000_00D5);
        ex(OP_MOV_A_IMM, 8'hAF);
        ex(OP_MOV_HST_A, 8'h00);
        chk("hostStatus", 32'h0000_00A1, {24'h0, hostStatus});
    endtask
    task automatic t_handshake;
        chk("plainOe", 32'h0, {28'h0, portTwoOe});
        ex(OP_EN_DMA, 8'h00);
        bus(1'b1, OFS_PORT_TWO, 32'h0000_00FF);
        rd(OFS_MODE, "request", 32'h0000_0005);
        chk("requestPin", 32'h0000_0003, {29'h0, portTwoOe[3:2], portTwoOut[2]});
        ack(1'b0, 4'h3);
        rd(OFS_MODE, "ackRead", 32'h0000_0001);
        chk("requestDrop", 32'h0000_0002, {29'h0, portTwoOe[3:2], portTwoOut[2]});
        bus(1'b1, OFS_PORT_TWO, 32'h0000_00FF);
        ack(1'b1, 4'h8);
        rd(OFS_MODE, "ackWrite", 32'h0000_0001);
        bus(1'b1, OFS_PORT_TWO, 32'h0000_00FF);
        ex(OP_EN_DMA, 8'h00);
        rd(OFS_MODE, "reEnable", 32'h0000_0001);
        ex(OP_EN_FLAGS, 8'h00);
        chk("flagPins", 32'h0000_000D, {28'h0, portTwoOe[1:0], portTwoOut[1:0]});
        inFull <= 1'b1;
        bus(1'b1, OFS_PORT_TWO, 32'h0000_00EF);
        #1 chk("gatedPins", 32'h0000_000E, {28'h0, portTwoOe[1:0], portTwoOut[1:0]});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_moves();
        t_memory();
        t_status();
        t_handshake();
        complete_run();
    end
    initial begin
        #200_000;
        n_errors++;
        complete_run();
    end
endmodule
bind smt_transfer_core smt_checker u_smt_checker (.clk(clk), .nrst(nrst), .hsel(hsel), .hwrite(hwrite),
    .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .hrdata(hrdata), .htrans(htrans), .outFull(outFull),
    .inFull(inFull), .hostCsN(hostCsN), .hostSelN(hostSelN), .hostStatus(hostStatus), .portTwoIn(portTwoIn),
    .portTwoOut(portTwoOut), .portTwoOe(portTwoOe));
